// ===== srm_params.svh
// Purpose: constants of the sensor result register file
// Assumes: byte-wide register port driven by the serial engine
// Notes:   addresses are the byte addresses seen by the host
//
// What this block does
// RULE1 - The primary result holds altitude when height mode is one and pressure when zero; height_mode_select is unused and the sample is stored as given.
// RULE2 - Altitude is a 20-bit signed value with 16 integer and 4 fraction bits.
// RULE3 - Pressure is a 20-bit unsigned value with 18 integer and 2 fraction bits.
// RULE4 - Pressure integer fills high, mid and low bits 7:6, fraction low bits 5:4.
// RULE5 - The address auto-increments so 00h to 05h can be read in one burst.
// RULE6 - Temperature is a 12-bit signed value with 8 integer and 4 fraction bits.
// RULE7 - Temperature integer sits at 04h, fraction in bits 7:4 of 05h, low nibble zero.
// RULE8 - 07h to 09h hold current minus previous primary sample in the selected format.
// RULE9 - Altitude change puts 16 integer bits in the upper bytes and 4 fraction bits at 7:4.
// RULE10 - Pressure change puts 18 integer bits high and the fraction in bits 5:4.
// RULE11 - Change registers keep updating whatever the queue mode is.
// RULE12 - 0Ah and 0Bh hold the signed 12-bit temperature change, integer byte first.
// RULE13 - 0Ch returns a fixed 8-bit identification code.
// RULE14 - With the queue off the result registers show the latest sample directly.
// RULE15 - With the queue on, reads of 02h to 05h return 00h.
// RULE16 - With the queue off, reading 01h or 04h clears the matching ready flags.
// RULE17 - Reserved nibbles read zero and host writes change nothing.
`ifndef SRM_PARAMS_SVH
`define SRM_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SRM_ADDR_STATUS    8'h00
`define SRM_ADDR_PRES_HI   8'h01
`define SRM_ADDR_PRES_MID  8'h02
`define SRM_ADDR_PRES_LO   8'h03
`define SRM_ADDR_TEMP_HI   8'h04
`define SRM_ADDR_TEMP_LO   8'h05
`define SRM_ADDR_UNUSED    8'h06
`define SRM_ADDR_PCHG_HI   8'h07
`define SRM_ADDR_PCHG_MID  8'h08
`define SRM_ADDR_PCHG_LO   8'h09
`define SRM_ADDR_TCHG_HI   8'h0A
`define SRM_ADDR_TCHG_LO   8'h0B
`define SRM_ADDR_PART_ID   8'h0C

// ----------------------------------------------------------------
// reset values and fixed codes
// ----------------------------------------------------------------
`define SRM_RESET_BYTE     8'h00
`define SRM_RESET_PRIMARY  20'h0_0000
`define SRM_RESET_TEMP     12'h000
// arbitrary neutral identification value
`define SRM_PART_ID_VALUE  8'h5A
`define SRM_PAD_NIBBLE     4'h0

`endif

// ===== srm_pkg.sv
// Purpose: types shared by the sensor result register file
// Assumes: nothing beyond the params header
// Notes:   widths follow the documented sample formats
package srm_pkg;

  // ----------------------------------------------------------------
  // sample and byte types
  // ----------------------------------------------------------------
  typedef logic [7:0]  srm_byte_t;
  typedef logic [19:0] srm_primary_t;
  typedef logic [11:0] srm_temp_t;

  // queue mode field, only "off" matters to this block
  typedef enum logic [1:0] {
    SRM_QUEUE_OFF      = 2'b00,
    SRM_QUEUE_CIRCULAR = 2'b01,
    SRM_QUEUE_STOP     = 2'b10,
    SRM_QUEUE_RSVD     = 2'b11
  } srm_queue_mode_t;

endpackage : srm_pkg

// ===== srm_result_regs.sv
// Purpose: read-only result and change registers of the sensor
// Assumes: serial engine gives one-cycle start, read and write pulses
// Notes:   read data appears one cycle after the read pulse
`timescale 1ns/1ps
`include "srm_params.svh"

module srm_result_regs #(
  parameter srm_pkg::srm_byte_t PART_ID = `SRM_PART_ID_VALUE // arbitrary value
) (
  input  wire logic                     ref_clk,           // 100 MHz clock
  input  wire logic                     rst_b,             // async reset, low
  input  wire logic                     height_mode_select,// 1 altitude, 0 pressure
  input  wire srm_pkg::srm_queue_mode_t queue_mode,        // queue mode field
  input  wire logic                     primary_valid,     // new primary sample pulse
  input  wire srm_pkg::srm_primary_t    primary_sample,    // formatted primary sample
  input  wire logic                     temp_valid,        // new temperature pulse
  input  wire srm_pkg::srm_temp_t       temp_sample,       // temperature sample
  input  wire srm_pkg::srm_byte_t       status_byte,       // status register image
  input  wire srm_pkg::srm_byte_t       queue_byte,        // queue head byte
  input  wire logic                     reg_start,         // load address pulse
  input  wire srm_pkg::srm_byte_t       reg_addr,          // start address
  input  wire logic                     reg_rd,            // read one byte pulse
  input  wire logic                     reg_wr,            // write one byte pulse
  output srm_pkg::srm_byte_t            reg_rdata,         // read data
  output logic                          reg_rvalid,        // read data valid pulse
  output logic                          primary_read_clear,// clear primary flags
  output logic                          temp_read_clear,   // clear temperature flags
  output logic                          queue_pop          // queue byte consumed
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  srm_pkg::srm_primary_t primary;
  srm_pkg::srm_primary_t primary_chg;
  srm_pkg::srm_temp_t    temp;
  srm_pkg::srm_temp_t    temp_chg;
  srm_pkg::srm_byte_t    ptr;
  srm_pkg::srm_primary_t next_primary;
  srm_pkg::srm_primary_t next_primary_chg;
  srm_pkg::srm_temp_t    next_temp;
  srm_pkg::srm_temp_t    next_temp_chg;
  srm_pkg::srm_byte_t    next_ptr;
  srm_pkg::srm_byte_t    next_rdata;
  logic                  next_rvalid;
  logic                  next_pclr;
  logic                  next_tclr;
  logic                  next_pop;
  srm_pkg::srm_byte_t    eff_addr;
  logic                  queue_on;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // byte seen at an address; used only by the read path, the checks spell out their own bytes
  function automatic srm_pkg::srm_byte_t read_byte(
    input srm_pkg::srm_byte_t    addr,
    input logic                  qon,
    input srm_pkg::srm_byte_t    stat,
    input srm_pkg::srm_byte_t    qbyte,
    input srm_pkg::srm_primary_t p,
    input srm_pkg::srm_primary_t pc,
    input srm_pkg::srm_temp_t    t,
    input srm_pkg::srm_temp_t    tc,
    input srm_pkg::srm_byte_t    id
  );
    srm_pkg::srm_byte_t b;
    b = `SRM_RESET_BYTE;
    if (addr == `SRM_ADDR_STATUS) begin
      b = stat;
    // RULE1 primary high byte
    end else if (addr == `SRM_ADDR_PRES_HI) begin
      b = qon ? qbyte : p[19:12];
    // RULE15 queue hides 02h-05h
    end else if (qon && addr >= `SRM_ADDR_PRES_MID && addr <= `SRM_ADDR_TEMP_LO) begin
      b = `SRM_RESET_BYTE;
    end else if (addr == `SRM_ADDR_PRES_MID) begin
      b = p[11:4];
    // RULE4 bits 3:0 at 7:4, pad zero
    end else if (addr == `SRM_ADDR_PRES_LO) begin
      b = {p[3:0], `SRM_PAD_NIBBLE};
    // RULE7 temperature bytes
    end else if (addr == `SRM_ADDR_TEMP_HI) begin
      b = t[11:4];
    end else if (addr == `SRM_ADDR_TEMP_LO) begin
      b = {t[3:0], `SRM_PAD_NIBBLE};
    // RULE9 change bytes, same layout as result
    end else if (addr == `SRM_ADDR_PCHG_HI) begin
      b = pc[19:12];
    end else if (addr == `SRM_ADDR_PCHG_MID) begin
      b = pc[11:4];
    // RULE10 change low byte
    end else if (addr == `SRM_ADDR_PCHG_LO) begin
      b = {pc[3:0], `SRM_PAD_NIBBLE};
    // RULE12 temperature change bytes
    end else if (addr == `SRM_ADDR_TCHG_HI) begin
      b = tc[11:4];
    end else if (addr == `SRM_ADDR_TCHG_LO) begin
      b = {tc[3:0], `SRM_PAD_NIBBLE};
    // RULE13 identification code
    end else if (addr == `SRM_ADDR_PART_ID) begin
      b = id;
    end
    return b;
  endfunction : read_byte

  assign queue_on = (queue_mode != srm_pkg::SRM_QUEUE_OFF);
  // a read in the same cycle as start uses the fresh address
  assign eff_addr = reg_start ? reg_addr : ptr;

  // ----------------------------------------------------------------
  // sample capture and change values
  // ----------------------------------------------------------------
  // one bit pattern serves both formats, so the subtraction is the
  // same modular 20-bit difference whether signed or unsigned
  always_comb begin
    next_primary     = primary;
    next_primary_chg = primary_chg;
    next_temp        = temp;
    next_temp_chg    = temp_chg;
    // RULE2 RULE3 bits kept as given
    // RULE14 latest sample shown directly
    if (primary_valid) begin
      next_primary     = primary_sample;
      // RULE8 current minus previous
      next_primary_chg = primary_sample - primary;
    end
    // RULE6 signed Q8.4 kept
    // RULE11 updated whatever the queue mode
    if (temp_valid) begin
      next_temp     = temp_sample;
      next_temp_chg = temp_sample - temp;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      primary     <= `SRM_RESET_PRIMARY;
      primary_chg <= `SRM_RESET_PRIMARY;
      temp        <= `SRM_RESET_TEMP;
      temp_chg    <= `SRM_RESET_TEMP;
    end else begin
      primary     <= next_primary;
      primary_chg <= next_primary_chg;
      temp        <= next_temp;
      temp_chg    <= next_temp_chg;
    end
  end

  // ----------------------------------------------------------------
  // host access path
  // ----------------------------------------------------------------
  always_comb begin
    next_ptr    = reg_start ? reg_addr : ptr;
    next_rdata  = reg_rdata;
    next_rvalid = 1'b0;
    next_pclr   = 1'b0;
    next_tclr   = 1'b0;
    next_pop    = 1'b0;
    if (reg_rd) begin
      next_rdata  = read_byte(eff_addr, queue_on, status_byte, queue_byte,
                              primary, primary_chg, temp, temp_chg, PART_ID);
      next_rvalid = 1'b1;
      // RULE16 high byte read clears flags
      next_pclr = !queue_on && eff_addr == `SRM_ADDR_PRES_HI;
      next_tclr = !queue_on && eff_addr == `SRM_ADDR_TEMP_HI;
      next_pop  = queue_on && eff_addr == `SRM_ADDR_PRES_HI;
    end
    // RULE5 auto-increment on each byte
    // RULE17 writes only move the pointer
    if (reg_rd || reg_wr) begin
      next_ptr = eff_addr + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr                <= `SRM_RESET_BYTE;
      reg_rdata          <= `SRM_RESET_BYTE;
      reg_rvalid         <= 1'b0;
      primary_read_clear <= 1'b0;
      temp_read_clear    <= 1'b0;
      queue_pop          <= 1'b0;
    end else begin
      ptr                <= next_ptr;
      reg_rdata          <= next_rdata;
      reg_rvalid         <= next_rvalid;
      primary_read_clear <= next_pclr;
      temp_read_clear    <= next_tclr;
      queue_pop          <= next_pop;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PRIMARY_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE1
    primary_valid |=> primary == $past(primary_sample))
    else $error("primary sample not captured");

  AST_ALT_SIGN: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE2
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_PRES_HI && !primary_valid
    |=> reg_rdata[7] == primary[19])
    else $error("altitude sign bit misplaced");

  AST_PRES_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_PRES_LO && !primary_valid
    |=> reg_rdata == {primary[3:0], 4'h0})
    else $error("low primary byte wrong");

  AST_AUTOINC: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
    reg_rd && !reg_start ##1 reg_rd && !reg_start
    |-> ptr == $past(ptr, 1) + 8'h01)
    else $error("address did not advance");

  AST_TEMP_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE7
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_TEMP_LO && !temp_valid
    |=> reg_rdata[3:0] == 4'h0 && reg_rdata[7:4] == temp[3:0])
    else $error("temperature low byte wrong");

  AST_PCHG: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE8
    primary_valid |=> primary_chg == primary - $past(primary))
    else $error("primary change wrong");

  AST_TCHG: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
    temp_valid && queue_on |=> temp_chg == temp - $past(temp))
    else $error("temperature change wrong");

  AST_PART_ID: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE13
    reg_rd && eff_addr == `SRM_ADDR_PART_ID |=> reg_rvalid && reg_rdata == PART_ID)
    else $error("identification code wrong");

  AST_QUEUE_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE15
    reg_rd && queue_on && eff_addr >= `SRM_ADDR_PRES_MID
    && eff_addr <= `SRM_ADDR_TEMP_LO |=> reg_rdata == 8'h00)
    else $error("hidden register not zero");

  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE16
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_TEMP_HI
    |=> temp_read_clear)
    else $error("temperature clear pulse wrong");

  AST_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE17
    reg_wr && !primary_valid && !temp_valid |=> $stable(primary) && $stable(temp))
    else $error("write changed a result");

  AST_PRIMARY_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE16
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_PRES_HI
    |=> primary_read_clear)
    else $error("primary clear pulse missing");

  // back-to-back high byte reads may keep a clear high, so only cycles without such a read are checked
  AST_CLEAR_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE16
    !(reg_rd && !queue_on && (eff_addr == `SRM_ADDR_PRES_HI || eff_addr == `SRM_ADDR_TEMP_HI))
    |=> !primary_read_clear && !temp_read_clear)
    else $error("flag clear without a high byte read");

  AST_QUEUE_POP: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE15
    reg_rd && queue_on && eff_addr == `SRM_ADDR_PRES_HI
    |=> queue_pop && reg_rdata == $past(queue_byte))
    else $error("queue byte not returned");

  AST_PRES_MID: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE4
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_PRES_MID && !primary_valid
    |=> reg_rdata == primary[11:4])
    else $error("middle primary byte wrong");

  AST_TEMP_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
    reg_rd && !queue_on && eff_addr == `SRM_ADDR_TEMP_HI && !temp_valid
    |=> reg_rdata == temp[11:4])
    else $error("temperature high byte wrong");

  AST_TEMP_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE11
    temp_valid |=> temp == $past(temp_sample))
    else $error("temperature sample not captured");

  AST_PCHG_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE9
    reg_rd && eff_addr == `SRM_ADDR_PCHG_HI && !primary_valid
    |=> reg_rdata == primary_chg[19:12])
    else $error("primary change high byte wrong");

  AST_PCHG_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE10
    reg_rd && eff_addr == `SRM_ADDR_PCHG_LO && !primary_valid
    |=> reg_rdata == {primary_chg[3:0], 4'h0})
    else $error("primary change low byte wrong");

  AST_TCHG_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
    reg_rd && eff_addr == `SRM_ADDR_TCHG_LO && !temp_valid
    |=> reg_rdata == {temp_chg[3:0], 4'h0})
    else $error("temperature change low byte wrong");

  AST_STATUS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
    reg_rd && eff_addr == `SRM_ADDR_STATUS
    |=> reg_rvalid && reg_rdata == $past(status_byte))
    else $error("status byte not returned");

  AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE17
    reg_rd && (eff_addr == `SRM_ADDR_UNUSED || eff_addr > `SRM_ADDR_PART_ID)
    |=> reg_rdata == 8'h00)
    else $error("unmapped address not zero");

  AST_NO_ANSWER: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE17
    !reg_rd |=> !reg_rvalid)
    else $error("answer without a read");

endmodule : srm_result_regs

// ===== srm_host_model.sv
// Purpose: host model that drives the register port and the sample inputs
// Assumes: one-cycle request pulses, answer one cycle after the read
// Notes:   released address and sample lines show the inverse of their last value, pulse lines go low
`timescale 1ns/1ps

module srm_host_model (
  input  wire logic           ref_clk,        // clock
  output srm_pkg::srm_byte_t  reg_addr,       // start address
  output logic                reg_start,      // load pointer pulse
  output logic                reg_rd,         // read pulse
  output logic                reg_wr,         // write pulse
  output logic                primary_valid,  // sample pulse
  output srm_pkg::srm_primary_t primary_sample, // primary sample
  output logic                temp_valid,     // temperature pulse
  output srm_pkg::srm_temp_t  temp_sample,    // temperature sample
  input  wire srm_pkg::srm_byte_t reg_rdata,  // read data
  input  wire logic           reg_rvalid,     // read data valid
  input  wire logic [2:0]     flags           // pop, temp clear, primary clear
);
  logic [10:0] got[$]; // answers with their side pulses

  initial begin
    {reg_addr, reg_start, reg_rd, reg_wr} = '0;
    {primary_valid, primary_sample, temp_valid, temp_sample} = '0;
  end

  // ----------------------------------------------------------------
  // request driving
  // ----------------------------------------------------------------
  // back-to-back burst
  task automatic burst(input srm_pkg::srm_byte_t a, input int n, input logic wr,
                       input logic st);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      reg_start <= st && (i == 0);
      reg_addr  <= a;
      reg_rd    <= !wr;
      reg_wr    <= wr;
    end
    @(posedge ref_clk);
    reg_start <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
  endtask : burst

  task automatic sample(input srm_pkg::srm_primary_t p, input srm_pkg::srm_temp_t t);
    @(posedge ref_clk);
    primary_valid  <= 1'b1;
    primary_sample <= p;
    temp_valid     <= 1'b1;
    temp_sample    <= t;
    @(posedge ref_clk);
    primary_valid  <= 1'b0;
    temp_valid     <= 1'b0;
    primary_sample <= ~p; // stale value must not be taken
    temp_sample    <= ~t;
  endtask : sample

  // ----------------------------------------------------------------
  // answer capture
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      got.push_back({flags, reg_rdata});
    end
  end
endmodule : srm_host_model

// ===== srm_result_regs_tb.sv
// Purpose: self-checking bench for the sensor result register file
// Assumes: host model speaks the byte register port
// Notes:   expected bytes are built from the sample formats
`timescale 1ns/1ps

module srm_result_regs_tb;
  localparam srm_pkg::srm_byte_t ID  = 8'hA5; // arbitrary value
  localparam logic [10:0]        NIL = 11'h000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic height_mode_select = 1'b0;
  srm_pkg::srm_queue_mode_t queue_mode = srm_pkg::SRM_QUEUE_OFF;
  srm_pkg::srm_byte_t status_byte = 8'h3C;
  srm_pkg::srm_byte_t queue_byte = 8'h00;
  srm_pkg::srm_byte_t reg_addr, reg_rdata;
  srm_pkg::srm_primary_t primary_sample, prev_p = '0;
  srm_pkg::srm_temp_t temp_sample, prev_t = '0;
  logic reg_start, reg_rd, reg_wr, primary_valid, temp_valid, reg_rvalid;
  logic primary_read_clear, temp_read_clear, queue_pop;
  int n_fail = 0;
  int tests_run = 0;

  always #5 ref_clk = ~ref_clk;

  srm_result_regs #(.PART_ID(ID)) srm_result_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .height_mode_select(height_mode_select), .queue_mode(queue_mode),
    .primary_valid(primary_valid), .primary_sample(primary_sample), .temp_valid(temp_valid),
    .temp_sample(temp_sample), .status_byte(status_byte), .queue_byte(queue_byte),
    .reg_start(reg_start), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .primary_read_clear(primary_read_clear),
    .temp_read_clear(temp_read_clear), .queue_pop(queue_pop));

  srm_host_model srm_host_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_start(reg_start), .reg_rd(reg_rd), .reg_wr(reg_wr), .primary_valid(primary_valid),
    .primary_sample(primary_sample), .temp_valid(temp_valid), .temp_sample(temp_sample),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .flags({queue_pop, temp_read_clear, primary_read_clear}));

  // ----------------------------------------------------------------
  // checking tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // flags and byte of each answer, bounded wait for all of them
  task automatic rd(input srm_pkg::srm_byte_t a, input int n, input logic st,
                    input logic [10:0] e [8]);
    srm_host_model_inst.got.delete();
    srm_host_model_inst.burst(a, n, 1'b0, st);
    for (int k = 0; k < 20 && srm_host_model_inst.got.size() < n; k++) begin
      @(posedge ref_clk);
    end
    if (srm_host_model_inst.got.size() < n) begin
      n_fail++;
      $display("BAD answers from %h expected %0d seen %0d", a, n,
               srm_host_model_inst.got.size());
      summarize();
    end
    for (int k = 0; k < n; k++) begin
      check($sformatf("byte at %h", 8'(a + k)), srm_host_model_inst.got[k], e[k]);
    end
  endtask : rd

  task automatic sample_check(input srm_pkg::srm_primary_t p, input srm_pkg::srm_temp_t t);
    srm_pkg::srm_primary_t dp;
    srm_pkg::srm_temp_t    dt;
    dp = p - prev_p;
    dt = t - prev_t;
    prev_p = p;
    prev_t = t;
    srm_host_model_inst.sample(p, t);
    rd(8'h07, 5, 1'b1, '{{3'h0, dp[19:12]}, {3'h0, dp[11:4]},
       {3'h0, dp[3:0], 4'h0}, {3'h0, dt[11:4]}, {3'h0, dt[3:0], 4'h0}, NIL, NIL, NIL});
  endtask : sample_check

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'h00, 6, 1'b1, '{11'h03C, 11'h100, NIL, NIL, 11'h200, NIL, NIL, NIL});
    sample_check(20'hA_BCDE, 12'h9A7);
    rd(8'h00, 6, 1'b1, '{11'h03C, 11'h1AB, 11'h0CD, 11'h0E0, 11'h29A, 11'h070, NIL, NIL});
    @(posedge ref_clk);
    height_mode_select <= 1'b1;
    sample_check(20'hF_FF12, 12'h1F0);
    rd(8'h01, 3, 1'b1, '{11'h1FF, 11'h0F1, 11'h020, NIL, NIL, NIL, NIL, NIL});
    rd(8'h0C, 2, 1'b1, '{{3'h0, ID}, NIL, NIL, NIL, NIL, NIL, NIL, NIL});
    rd(8'hFF, 2, 1'b1, '{NIL, 11'h03C, NIL, NIL, NIL, NIL, NIL, NIL});
    rd(8'h06, 1, 1'b1, '{NIL, NIL, NIL, NIL, NIL, NIL, NIL, NIL});
    // every queue-on mode diverts 01h and blanks 02h to 05h
    for (int m = 1; m < 4; m++) begin
      @(posedge ref_clk);
      queue_mode <= srm_pkg::srm_queue_mode_t'(m);
      queue_byte <= {6'h18, 2'(m)};
      sample_check(20'(m * 20'h1_2345), 12'(12'h0F0 - m));
      rd(8'h01, 5, 1'b1, '{{3'h4, 6'h18, 2'(m)}, NIL, NIL, NIL, NIL, NIL, NIL, NIL});
    end
    @(posedge ref_clk);
    queue_mode <= srm_pkg::SRM_QUEUE_OFF;
    // writes give no answer and change nothing, yet move the pointer
    srm_host_model_inst.got.delete();
    srm_host_model_inst.burst(8'h01, 2, 1'b1, 1'b1);
    repeat (3) @(posedge ref_clk);
    check("write answers", 11'(srm_host_model_inst.got.size()), NIL);
    rd(8'h00, 1, 1'b0, '{{3'h0, prev_p[3:0], 4'h0}, NIL, NIL, NIL, NIL, NIL, NIL, NIL});
    rd(8'h01, 1, 1'b1, '{{3'h1, prev_p[19:12]}, NIL, NIL, NIL, NIL, NIL, NIL, NIL});
    summarize();
  end
endmodule : srm_result_regs_tb
